// ==== inc/edam_pkg.sv ====
// Purpose: constants for the external data address mapper
// Assumes: register indices are scaled by four to give APB byte addresses
// Notes:   mode codes 10 and 11 route like internal-only
package edam_pkg;
    localparam int          APB_AW        = 12;
    localparam int          EXT_AW        = 12;
    localparam int          LO_W          = 8;
    localparam int          RAM_SIZE_DEF  = 4096;
    // register indices and byte addresses
    localparam logic [7:0]  IDX_PAGE      = 8'hAA;
    localparam logic [7:0]  IDX_CONFIG    = 8'hAB;
    localparam logic [7:0]  IDX_TIMING    = 8'hAF;
    localparam logic [7:0]  IDX_STATUS    = 8'hB0;
    localparam logic [APB_AW-1:0] ADDR_PAGE   = {2'h0, IDX_PAGE, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_TIMING = {2'h0, IDX_TIMING, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
    // reset values
    localparam logic [7:0]  RST_PAGE      = 8'h00;
    localparam logic [7:0]  RST_CONFIG    = 8'h00;
    localparam logic [7:0]  RST_TIMING    = 8'h00;
    // mode field of the config register
    localparam int          MODE_LSB      = 2;
    localparam int          MODE_MSB      = 3;
    localparam logic [1:0]  MODE_INT_ONLY = 2'h0;
    localparam logic [1:0]  MODE_SPLIT_NB = 2'h1;
    // status register fields
    localparam int          STAT_OFF_BIT  = 0;
    localparam int          STAT_16_BIT   = 1;
endpackage : edam_pkg

// ==== hw/edam_top.sv ====
// Purpose: routes external data moves to on-chip RAM or off-chip address pins
// Assumes: core gives index register value, data pointer and a one-cycle request
// Notes:   RAM_SIZE must be a power of two; results appear one cycle after request
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module edam_top #(
    parameter int RAM_SIZE = edam_pkg::RAM_SIZE_DEF
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [edam_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output var  logic [31:0]                  prdata,
    output var  logic                         pready,
    output var  logic                         pslverr,
    input  wire logic                         external_data_move_req,
    input  wire logic                         external_data_move_wide,
    input  wire logic                         external_data_move_wr,
    input  wire logic [7:0]                   index_reg,
    input  wire logic [15:0]                  data_ptr,
    output var  logic                         ram_en,
    output var  logic                         ram_wr,
    output var  logic [$clog2(RAM_SIZE)-1:0]  ram_addr,
    output var  logic                         ext_en,
    output var  logic                         ext_wr,
    output var  logic [edam_pkg::EXT_AW-1:0]  ext_addr,
    output var  logic                         ext_hi_oe,
    output var  logic                         ext_lo_oe,
    output var  logic [7:0]                   timing_cfg
);
    localparam int AW = $clog2(RAM_SIZE);
    localparam logic [16:0] BOUNDARY = 17'(RAM_SIZE);

    typedef struct packed {
        logic [7:0]                   page;
        logic [7:0]                   cfg;
        logic [7:0]                   tmg;
        logic                         last_off;
        logic                         last_wide;
        logic                         pready;
        logic                         pslverr;
        logic [31:0]                  prdata;
        logic                         ram_en;
        logic                         ram_wr;
        logic [AW-1:0]                ram_addr;
        logic                         ext_en;
        logic                         ext_wr;
        logic [edam_pkg::EXT_AW-1:0]  ext_addr;
        logic                         ext_hi_oe;
        logic                         ext_lo_oe;
    } edam_state_t;

    edam_state_t st_r;
    edam_state_t st_nxt;

    logic [1:0]   mode;
    logic [15:0]  eff_addr;
    logic         split;
    logic         off_chip;
    logic         setup_ph;
    logic         access_ph;
    logic         mapped;
    logic [31:0]  rd_word;

    // mode decode and effective address
    assign mode = st_r.cfg[edam_pkg::MODE_MSB:edam_pkg::MODE_LSB];
    assign split = (mode == edam_pkg::MODE_SPLIT_NB);
    assign eff_addr = external_data_move_wide ? data_ptr : {st_r.page, index_reg};
    assign off_chip = split && ({1'b0, eff_addr} >= BOUNDARY);

    // apb phase decode
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable && st_r.pready;

    // read mux and address decode
    always_comb begin
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            edam_pkg::ADDR_PAGE:   rd_word[7:0] = st_r.page;
            edam_pkg::ADDR_CONFIG: rd_word[7:0] = st_r.cfg;
            edam_pkg::ADDR_TIMING: rd_word[7:0] = st_r.tmg;
            edam_pkg::ADDR_STATUS: begin
                rd_word[edam_pkg::STAT_OFF_BIT] = st_r.last_off;
                rd_word[edam_pkg::STAT_16_BIT]  = st_r.last_wide;
            end
            default:               mapped = 1'b0;
        endcase
    end

    // next state: bus slave and move routing
    always_comb begin
        st_nxt = st_r;
        // one wait-free access phase answered from a flop
        st_nxt.pready  = setup_ph;
        st_nxt.pslverr = setup_ph && !mapped;
        st_nxt.prdata  = (setup_ph && !pwrite) ? rd_word : 32'h0000_0000;
        if (access_ph && pwrite && mapped) begin
            unique case (paddr)
                edam_pkg::ADDR_PAGE:   st_nxt.page = pwdata[7:0];
                edam_pkg::ADDR_CONFIG: st_nxt.cfg  = pwdata[7:0];
                edam_pkg::ADDR_TIMING: st_nxt.tmg  = pwdata[7:0];
                default:               st_nxt.cfg  = st_r.cfg;
            endcase
        end
        // strobes are one-cycle pulses
        st_nxt.ram_en    = 1'b0;
        st_nxt.ram_wr    = 1'b0;
        st_nxt.ext_en    = 1'b0;
        st_nxt.ext_wr    = 1'b0;
        st_nxt.ext_hi_oe = 1'b0;
        st_nxt.ext_lo_oe = 1'b0;
        if (external_data_move_req) begin
            st_nxt.last_off  = off_chip;
            st_nxt.last_wide = external_data_move_wide;
            if (!off_chip) begin
                st_nxt.ram_en   = 1'b1;
                st_nxt.ram_wr   = external_data_move_wr;
                st_nxt.ram_addr = eff_addr[AW-1:0];
            end else begin
                st_nxt.ext_en    = 1'b1;
                st_nxt.ext_wr    = external_data_move_wr;
                st_nxt.ext_lo_oe = 1'b1;
                st_nxt.ext_addr  = eff_addr[edam_pkg::EXT_AW-1:0];
                st_nxt.ext_hi_oe = external_data_move_wide;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r           <= '0;
            st_r.page      <= edam_pkg::RST_PAGE;
            st_r.cfg       <= edam_pkg::RST_CONFIG;
            st_r.tmg       <= edam_pkg::RST_TIMING;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign prdata     = st_r.prdata;
    assign pready     = st_r.pready;
    assign pslverr    = st_r.pslverr;
    assign ram_en     = st_r.ram_en;
    assign ram_wr     = st_r.ram_wr;
    assign ram_addr   = st_r.ram_addr;
    assign ext_en     = st_r.ext_en;
    assign ext_wr     = st_r.ext_wr;
    assign ext_addr   = st_r.ext_addr;
    assign ext_hi_oe  = st_r.ext_hi_oe;
    assign ext_lo_oe  = st_r.ext_lo_oe;
    assign timing_cfg = st_r.tmg;

    // checks on routing
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_req_int;
        external_data_move_req && !split;
    endsequence

    sequence s_req_off8;
        external_data_move_req && split && !external_data_move_wide && off_chip;
    endsequence

    sequence s_req_off16;
        external_data_move_req && split && external_data_move_wide && off_chip;
    endsequence

    sequence s_req_on_split;
        external_data_move_req && split && ({1'b0, eff_addr} < BOUNDARY);
    endsequence

    mode_write_a: assert property (
        access_ph && pwrite && paddr == edam_pkg::ADDR_CONFIG
        |=> st_r.cfg == $past(pwdata[7:0]))
        else $error("config write not taken");

    int_only_a: assert property (
        external_data_move_req && mode == edam_pkg::MODE_INT_ONLY |=> ram_en && !ext_en && !ext_lo_oe)
        else $error("internal-only move left the chip");

    wrap_addr_a: assert property (
        s_req_int |=> ram_addr == $past(eff_addr[AW-1:0]))
        else $error("internal address did not wrap");

    page_addr_a: assert property (
        external_data_move_req && !external_data_move_wide && !split
        |=> ram_addr == $past(AW'({st_r.page, index_reg})))
        else $error("8-bit address not page and index");

    sixteen_bit_data_pointer_addr_a: assert property (
        external_data_move_req && external_data_move_wide && !split |=> ram_addr == $past(data_ptr[AW-1:0]))
        else $error("16-bit address not from pointer");

    split_on_a: assert property (
        s_req_on_split |=> ram_en && !ext_en)
        else $error("low split address went off-chip");

    page_route_a: assert property (
        external_data_move_req && split && !external_data_move_wide && ({1'b0, st_r.page, 8'h00} >= BOUNDARY)
        |=> ext_en && !ram_en)
        else $error("page above boundary stayed on-chip");

    hi_float_a: assert property (
        s_req_off8 |=> !ext_hi_oe ##1 !ext_hi_oe || ext_en)
        else $error("upper lines driven by 8-bit move");

    lo_index_a: assert property (
        s_req_off8 |=> ext_lo_oe && ext_addr[7:0] == $past(index_reg))
        else $error("low lines not index value");

    full_drive_a: assert property (
        s_req_off16 |=> ext_hi_oe && ext_lo_oe && ext_addr == $past(data_ptr[11:0]))
        else $error("16-bit off-chip move not fully driven");

    resv_mode_a: assert property (
        external_data_move_req && mode[1] |=> ram_en && !ext_en)
        else $error("reserved mode left the chip");

    pulse_len_a: assert property (
        !external_data_move_req |=> !ram_en && !ext_en)
        else $error("strobe without request");

    // checks on the register bus
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    ready_setup_a: assert property (
        psel && !penable |=> pready)
        else $error("setup phase not answered");

    unmapped_err_a: assert property (
        psel && !penable && !mapped |=> pready && pslverr)
        else $error("unmapped address not flagged");

    err_with_ready_a: assert property (
        pslverr |-> pready)
        else $error("error flag outside access phase");

    rdata_idle_a: assert property (
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access phase");

    status_read_a: assert property (
        psel && !penable && !pwrite && paddr == edam_pkg::ADDR_STATUS
        |=> prdata[1:0] == $past({st_r.last_wide, st_r.last_off}))
        else $error("status read does not show last move");

    refused_write_a: assert property (
        access_ph && pwrite && !mapped
        |=> st_r.page == $past(st_r.page) && st_r.cfg == $past(st_r.cfg)
            && st_r.tmg == $past(st_r.tmg))
        else $error("unmapped write changed a register");

    // checks on move strobes and held addresses
    one_route_a: assert property (
        external_data_move_req |=> ram_en != ext_en)
        else $error("move not routed to exactly one side");

    lo_with_en_a: assert property (
        ext_lo_oe == ext_en)
        else $error("low line drive not tied to off-chip strobe");

    hi_needs_lo_a: assert property (
        ext_hi_oe |-> ext_lo_oe && ext_en)
        else $error("upper lines driven outside off-chip move");

    ram_hold_a: assert property (
        !(external_data_move_req && !off_chip) |=> $stable(ram_addr))
        else $error("ram address moved without a request");

    ext_hold_a: assert property (
        !(external_data_move_req && off_chip) |=> $stable(ext_addr))
        else $error("off-chip address moved without a request");

    wr_strobe_a: assert property (
        external_data_move_req |=> (ram_wr || ext_wr) == $past(external_data_move_wr))
        else $error("write flag lost on a move");

endmodule : edam_top
`default_nettype wire

// ==== tb/edam_ext_mem.sv ====
// Purpose: off-chip memory model that sees the resolved address pins
// Assumes: port latches hold the upper nibble whenever the mapper lets it go
// Notes:   released low lines show the inverse of their last driven value
`timescale 1ns/1ns
`default_nettype none
module edam_ext_mem (
    input  wire logic        pclk,
    input  wire logic        ext_en,
    input  wire logic [11:0] ext_addr,
    input  wire logic        ext_hi_oe,
    input  wire logic        ext_lo_oe,
    input  wire logic [3:0]  latch_hi,
    output var  logic [11:0] pin_addr
);
    logic [7:0] lo_last = 8'h00;
    // pins follow the mapper where enabled, else latches or stale inverse
    always_comb begin
        pin_addr[11:8] = ext_hi_oe ? ext_addr[11:8] : latch_hi;
        pin_addr[7:0]  = ext_lo_oe ? ext_addr[7:0] : ~lo_last;
    end
    // remember the low byte of each strobed access
    always @(posedge pclk) begin
        if (ext_en) begin
            lo_last <= ext_addr[7:0];
        end
    end
endmodule : edam_ext_mem
`default_nettype wire

// ==== tb/test_external_data_address_mapper.sv ====
// Purpose: register and routing tests of the external data address mapper
// Assumes: on-chip RAM shrunk to 1024 bytes so wrap and split show up
// Notes:   expected routes are worked out here from mode, page and pointer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module test_external_data_address_mapper;
    logic        pclk, presetn, psel, penable, pwrite, external_data_move_req, external_data_move_wide, external_data_move_wr;
    logic [11:0] paddr, ext_addr, pin_addr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, ram_en, ram_wr, ext_en, ext_wr, ext_hi_oe, ext_lo_oe, e;
    logic [7:0]  index_reg, timing_cfg, cur_page;
    logic [15:0] data_ptr;
    logic [9:0]  ram_addr;
    logic [1:0]  cur_mode;
    int          n_errors = 0;
    int          n_checks = 0;
    edam_top #(.RAM_SIZE(1024)) edam_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_data_move_req(external_data_move_req), .external_data_move_wide(external_data_move_wide),
        .external_data_move_wr(external_data_move_wr), .index_reg(index_reg), .data_ptr(data_ptr), .ram_en(ram_en),
        .ram_wr(ram_wr), .ram_addr(ram_addr), .ext_en(ext_en), .ext_wr(ext_wr),
        .ext_addr(ext_addr), .ext_hi_oe(ext_hi_oe), .ext_lo_oe(ext_lo_oe),
        .timing_cfg(timing_cfg));
    edam_ext_mem edam_ext_mem_i (.pclk(pclk), .ext_en(ext_en), .ext_addr(ext_addr),
        .ext_hi_oe(ext_hi_oe), .ext_lo_oe(ext_lo_oe), .latch_hi(4'h9), .pin_addr(pin_addr));
    // clock at 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // read a register and compare data and error flag
    task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
        `CHK(e, xe)
    endtask : rchk
    // one move, then check route, strobes and address one cycle later
    task automatic mv(input logic wide, input logic wr, input logic [15:0] dp,
                      input logic [7:0] ix);
        logic [15:0] ea;
        logic        off;
        ea  = wide ? dp : {cur_page, ix};
        off = (cur_mode == 2'h1) && (ea >= 16'h0400);
        @(posedge pclk);
        external_data_move_req  <= 1'b1;
        external_data_move_wide <= wide;
        external_data_move_wr   <= wr;
        data_ptr  <= dp;
        index_reg <= ix;
        @(posedge pclk);
        external_data_move_req <= 1'b0;
        #1;
        `CHK({ram_en, ram_wr, ext_en, ext_wr}, {!off, wr & !off, off, wr & off})
        `CHK({ext_hi_oe, ext_lo_oe}, {off & wide, off})
        if (off) `CHK(pin_addr, {wide ? ea[11:8] : 4'h9, ea[7:0]})
        else `CHK(ram_addr, ea[9:0])
    endtask : mv
    // ends the run with the verdict
    task automatic wrap_up;
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, external_data_move_req, external_data_move_wide, external_data_move_wr} = 7'h00;
        {paddr, pwdata, index_reg, data_ptr, cur_page, cur_mode} = 78'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(edam_pkg::ADDR_PAGE, 32'h0, 1'b0);
        rchk(edam_pkg::ADDR_CONFIG, 32'h0, 1'b0);
        rchk(12'h004, 32'h0, 1'b1);
        apb(1'b1, edam_pkg::ADDR_TIMING, 32'hA5);
        rchk(edam_pkg::ADDR_TIMING, 32'hA5, 1'b0);
        `CHK(timing_cfg, 8'hA5)
        apb(1'b1, edam_pkg::ADDR_PAGE, 32'h12);
        cur_page = 8'h12;
        mv(1'b0, 1'b1, 16'h0, 8'h34);
        mv(1'b1, 1'b0, 16'hFFFF, 8'h0);
        apb(1'b1, edam_pkg::ADDR_CONFIG, 32'h04);
        cur_mode = 2'h1;
        rchk(edam_pkg::ADDR_CONFIG, 32'h04, 1'b0);
        apb(1'b1, edam_pkg::ADDR_PAGE, 32'h04);
        cur_page = 8'h04;
        mv(1'b0, 1'b1, 16'h0, 8'h5A);
        apb(1'b1, edam_pkg::ADDR_STATUS, 32'h2);
        rchk(edam_pkg::ADDR_STATUS, 32'h1, 1'b0);
        apb(1'b1, edam_pkg::ADDR_PAGE, 32'h03);
        cur_page = 8'h03;
        mv(1'b0, 1'b0, 16'hFFFF, 8'hFF);
        mv(1'b1, 1'b1, 16'h0ABC, 8'h00);
        mv(1'b1, 1'b0, 16'h0400, 8'h00);
        mv(1'b1, 1'b0, 16'h03FF, 8'h00);
        for (int m = 2; m < 4; m++) begin
            apb(1'b1, edam_pkg::ADDR_CONFIG, 32'(m) << 2);
            cur_mode = 2'(m);
            mv(1'b1, 1'b1, 16'h0ABC, 8'h00);
        end
        rchk(edam_pkg::ADDR_STATUS, 32'h2, 1'b0);
        apb(1'b1, edam_pkg::ADDR_CONFIG, 32'h04);
        // second reset in mid-run brings back internal-only routing
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {cur_page, cur_mode} = 10'h0;
        rchk(edam_pkg::ADDR_STATUS, 32'h0, 1'b0);
        rchk(edam_pkg::ADDR_CONFIG, 32'h0, 1'b0);
        mv(1'b1, 1'b0, 16'h0ABC, 8'h00);
        wrap_up();
    end
endmodule : test_external_data_address_mapper
`default_nettype wire
